// ### shared/pccard_pkg.sv
// constants, register map and carrier types of the power and ready block
package pccard_pkg;
    // register offsets
    localparam logic [3:0] ADDR_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CARD_STATUS = 4'h1;
    localparam logic [3:0] ADDR_CONFIG_OPTION = 4'h2;
    localparam logic [3:0] ADDR_EXT_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_EVENT_STATUS = 4'h4;
    localparam logic [3:0] ADDR_EVENT_MASK = 4'h5;
    localparam logic [3:0] ADDR_BLOCK_STATUS = 4'h6;
    // clock control fields
    localparam int BIT_LOW_POWER_ENABLE = 0;
    localparam int BIT_STOP_SELECT = 1;
    // card status fields
    localparam int BIT_INTERRUPT_PENDING_FLAG_PENDING = 0;
    localparam int BIT_POWER_DOWN = 1;
    localparam int BIT_RING_SRC_EN = 2;
    localparam int BIT_CHANGED_SRC_EN = 3;
    localparam int BIT_CHANGED = 4;
    // config option fields
    localparam int BIT_IO_MEM_MODE = 0;
    localparam int BIT_SOFT_RESET = 7;
    // event status bits
    localparam int EV_WAKE = 0;
    localparam int EV_LOAD_DONE = 1;
    localparam int EV_LOAD_ERROR = 2;
    localparam int EV_RESET_DONE = 3;
    localparam logic [7:0] RESET_VALUE_REG = 8'h00;
    // eeprom image format
    localparam logic [7:0] IMAGE_MARKER = 8'h02;
    localparam logic [15:0] HEADER_LEN_ADDR16 = 16'h0003;
    localparam logic [15:0] HEADER_LEN_ADDR8 = 16'h0004;
    localparam logic [15:0] IMAGE_MAX_BYTES = 16'h07FF;
    // timing at 40 mhz, 25 ns period
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLOCK_RECOVER_NS = 1000;
    localparam int RESET_ROUTINE_NS = 500;
    localparam logic [7:0] RECOVER_CYCLES =
        8'((CLOCK_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYCLES =
        8'((RESET_ROUTINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // pc card pins seen by the write decoder
    typedef struct packed {
        logic reg_n;
        logic ce2_n;
        logic ce1_n;
        logic a0;
        logic we_n;
        logic [15:0] data;
    } pc_bus_t;

    // steered common memory write
    typedef struct packed {
        logic valid;
        logic [1:0] lanes;
        logic [15:0] data;
    } cm_write_t;

    // dual port ram write from the image loader
    typedef struct packed {
        logic valid;
        logic [10:0] addr;
        logic [7:0] data;
    } dpr_write_t;
endpackage

// ### logic/pccard_power_ready_ctrl.sv
// pc card host port control: write steering, power modes, ready and image loader
`timescale 1ns/1ps
module pccard_power_ready_ctrl
    import pccard_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire pc_bus_t i_pc_bus,
    output cm_write_t o_cm_write,
    input wire logic i_ring_indicate_input,
    input wire logic [5:0] i_external_irq_inputs,
    input wire logic i_comm_processor_irq,
    input wire logic i_serial_eeprom_image_mode,
    input wire logic i_eeprom_addr16,
    output logic o_ee_rd,
    output logic [15:0] o_ee_addr,
    input wire logic i_ee_ack,
    input wire logic [7:0] i_ee_data,
    output dpr_write_t o_dual_port_ram_wr,
    output logic o_osc_enable,
    output logic o_int_clk_enable,
    output logic o_ready_irq_pin,
    output logic o_status_change_pin,
    output logic o_irq
);
    typedef enum logic [1:0] {PW_FULL, PW_STANDBY, PW_STOP, PW_RECOVER} power_state_t;
    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT} load_state_t;

    power_state_t power_reg;
    load_state_t load_reg;
    pc_bus_t pc_meta_reg, pc_sync_reg;
    logic pc_we_prev_reg;
    logic [1:0] ring_meta_reg;
    logic ring_prev_reg;
    logic [5:0] ext_meta_reg, ext_sync_reg;
    logic [1:0] mode_meta_reg, mode_sync_reg;
    logic [1:0] clock_control_reg;
    logic power_down_request;
    logic ring_src_en_reg, changed_src_en_reg;
    logic [7:0] config_option_reg;
    logic [5:0] ext_enable_reg;
    logic [3:0] event_status_reg, event_mask_reg;
    logic [7:0] recover_cnt_reg, reset_cnt_reg;
    logic reset_busy_reg, boot_reg;
    logic [15:0] byte_idx_reg, image_size_reg;
    logic load_error_reg;
    logic ready_reg;
    logic ring_edge, wr_clock, wr_status, wr_option, soft_reset_start;
    logic interrupt_pending_flag, changed_flag, start_load;
    logic [15:0] header_len;
    logic [3:0] event_set;
    logic load_done_pulse, load_err_pulse, reset_done_pulse, wake_pulse;

    // byte lanes of a common write: bit 0 even byte, bit 1 odd byte
    function automatic logic [1:0] write_lanes(input pc_bus_t b);
        logic [1:0] l;
        l = 2'b00;
        if (!b.ce1_n && b.ce2_n) begin
            l = b.a0 ? 2'b10 : 2'b01;
        end else if (!b.ce1_n && !b.ce2_n) begin
            l = 2'b11;
        end else if (b.ce1_n && !b.ce2_n) begin
            l = 2'b10;
        end
        return l;
    endfunction

    // two flip-flop synchronisers for the pc bus, ring and external irq inputs
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_meta_reg <= '1;
            pc_sync_reg <= '1;
            ring_meta_reg <= 2'b00;
            ext_meta_reg <= 6'h00;
            ext_sync_reg <= 6'h00;
        end else begin
            pc_meta_reg <= i_pc_bus;
            pc_sync_reg <= pc_meta_reg;
            ring_meta_reg <= {ring_meta_reg[0], i_ring_indicate_input};
            ext_meta_reg <= i_external_irq_inputs;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // straps sync through reset so the boot load sees them
    always_ff @(posedge i_sys_clk) begin
        mode_meta_reg <= {i_eeprom_addr16, i_serial_eeprom_image_mode};
        mode_sync_reg <= mode_meta_reg;
    end

    // edge history from the second stage
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_we_prev_reg <= 1'b1;
            ring_prev_reg <= 1'b0;
        end else begin
            pc_we_prev_reg <= pc_sync_reg.we_n;
            ring_prev_reg <= ring_meta_reg[1];
        end
    end

    // bus write decode
    assign wr_clock = i_reg_wr && (i_reg_addr == ADDR_CLOCK_CONTROL);
    assign wr_status = i_reg_wr && (i_reg_addr == ADDR_CARD_STATUS);
    assign wr_option = i_reg_wr && (i_reg_addr == ADDR_CONFIG_OPTION);
    assign ring_edge = ring_meta_reg[1] && !ring_prev_reg;
    assign soft_reset_start = wr_option && i_reg_wdata[BIT_SOFT_RESET];
    assign header_len = mode_sync_reg[1] ? HEADER_LEN_ADDR16 : HEADER_LEN_ADDR8;
    assign start_load = (boot_reg || soft_reset_start) && mode_sync_reg[0];
    assign interrupt_pending_flag = (|(ext_sync_reg & ext_enable_reg))
        || i_comm_processor_irq;
    assign changed_flag = interrupt_pending_flag || (event_status_reg != 4'h0);

    // common memory write steering on the rising edge of write enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cm_write <= '0;
        end else begin
            o_cm_write.valid <= 1'b0;
            if (pc_sync_reg.we_n && !pc_we_prev_reg && pc_sync_reg.reg_n
                && (write_lanes(pc_sync_reg) != 2'b00)) begin
                o_cm_write.valid <= 1'b1;
                o_cm_write.lanes <= write_lanes(pc_sync_reg);
                o_cm_write.data <= pc_sync_reg.data;
                if (!pc_sync_reg.ce1_n && pc_sync_reg.ce2_n && pc_sync_reg.a0) begin
                    // odd byte alone arrives on the low lanes
                    o_cm_write.data <= {pc_sync_reg.data[7:0], 8'h00};
                end
            end
        end
    end

    // clock control register holds the two mode bits
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            clock_control_reg <= 2'b00;
        end else if (wr_clock) begin
            clock_control_reg <= i_reg_wdata[1:0];
        end
    end

    // card status register: power down request and change sources
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            power_down_request <= 1'b0;
            ring_src_en_reg <= 1'b0;
            changed_src_en_reg <= 1'b0;
        end else begin
            if (ring_edge) begin
                power_down_request <= 1'b0;
            end
            if (wr_status) begin
                ring_src_en_reg <= i_reg_wdata[BIT_RING_SRC_EN];
                changed_src_en_reg <= i_reg_wdata[BIT_CHANGED_SRC_EN];
                // request is dropped while low power is disabled
                power_down_request <= i_reg_wdata[BIT_POWER_DOWN]
                    && clock_control_reg[BIT_LOW_POWER_ENABLE];
            end
        end
    end

    // config option and external interrupt enables
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            config_option_reg <= RESET_VALUE_REG;
            ext_enable_reg <= 6'h00;
        end else begin
            if (wr_option) begin
                config_option_reg <= i_reg_wdata;
            end
            if (i_reg_wr && (i_reg_addr == ADDR_EXT_IRQ_ENABLE)) begin
                ext_enable_reg <= i_reg_wdata[5:0];
            end
        end
    end

    // power mode state machine with clock recovery count
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            power_reg <= PW_FULL;
            recover_cnt_reg <= 8'h00;
        end else begin
            case (power_reg)
                PW_FULL: begin
                    if (power_down_request && clock_control_reg[BIT_LOW_POWER_ENABLE]) begin
                        power_reg <= clock_control_reg[BIT_STOP_SELECT]
                            ? PW_STOP : PW_STANDBY;
                    end
                end
                PW_STANDBY, PW_STOP: begin
                    if (!power_down_request || ring_edge) begin
                        power_reg <= PW_RECOVER;
                        recover_cnt_reg <= RECOVER_CYCLES;
                    end
                end
                default: begin
                    if (recover_cnt_reg <= 8'h01) begin
                        power_reg <= PW_FULL;
                    end else begin
                        recover_cnt_reg <= recover_cnt_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // clock gates follow the power mode
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_osc_enable <= 1'b1;
            o_int_clk_enable <= 1'b1;
        end else begin
            o_osc_enable <= (power_reg != PW_STOP);
            o_int_clk_enable <= (power_reg == PW_FULL);
        end
    end

    // soft reset routine timer, ended without software clearing the bit
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reset_busy_reg <= 1'b0;
            reset_cnt_reg <= 8'h00;
        end else if (soft_reset_start) begin
            reset_busy_reg <= 1'b1;
            reset_cnt_reg <= RESET_CYCLES;
        end else if (reset_busy_reg) begin
            reset_cnt_reg <= reset_cnt_reg - 8'h01;
            if (reset_cnt_reg <= 8'h01) begin
                reset_busy_reg <= 1'b0;
            end
        end
    end

    // boot load pulse after reset release
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    // serial eeprom image loader
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            load_reg <= LD_IDLE;
            byte_idx_reg <= 16'h0000;
            image_size_reg <= 16'h0000;
            load_error_reg <= 1'b0;
            o_ee_rd <= 1'b0;
            o_ee_addr <= 16'h0000;
            o_dual_port_ram_wr <= '0;
        end else begin
            o_ee_rd <= 1'b0;
            o_dual_port_ram_wr.valid <= 1'b0;
            case (load_reg)
                LD_IDLE: begin
                    if (start_load) begin
                        load_reg <= LD_REQ;
                        byte_idx_reg <= mode_sync_reg[1] ? 16'h0000 : 16'h0001;
                        image_size_reg <= 16'h0000;
                        load_error_reg <= 1'b0;
                    end
                end
                LD_REQ: begin
                    o_ee_rd <= 1'b1;
                    o_ee_addr <= byte_idx_reg;
                    load_reg <= LD_WAIT;
                end
                default: begin
                    if (i_ee_ack) begin
                        byte_idx_reg <= byte_idx_reg + 16'h0001;
                        load_reg <= LD_REQ;
                        if (byte_idx_reg == header_len - 16'h0003) begin
                            if (i_ee_data != IMAGE_MARKER) begin
                                load_error_reg <= 1'b1;
                                load_reg <= LD_IDLE;
                            end
                        end else if (byte_idx_reg == header_len - 16'h0002) begin
                            image_size_reg[15:8] <= i_ee_data;
                        end else if (byte_idx_reg == header_len - 16'h0001) begin
                            image_size_reg[7:0] <= i_ee_data;
                            if ({image_size_reg[15:8], i_ee_data} == 16'h0000) begin
                                load_reg <= LD_IDLE;
                            end else if ({image_size_reg[15:8], i_ee_data} > IMAGE_MAX_BYTES) begin
                                image_size_reg <= IMAGE_MAX_BYTES;
                            end
                        end else begin
                            o_dual_port_ram_wr.valid <= 1'b1;
                            o_dual_port_ram_wr.addr <= 11'(byte_idx_reg - header_len);
                            o_dual_port_ram_wr.data <= i_ee_data;
                            if (byte_idx_reg - header_len + 16'h0001 >= image_size_reg) begin
                                load_reg <= LD_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // event pulses for the interrupt status register
    assign load_done_pulse = (load_reg == LD_WAIT) && i_ee_ack && !start_load
        && (byte_idx_reg >= header_len - 16'h0001)
        && (byte_idx_reg == header_len - 16'h0001
            ? {image_size_reg[15:8], i_ee_data} == 16'h0000
            : byte_idx_reg - header_len + 16'h0001 >= image_size_reg);
    assign load_err_pulse = (load_reg == LD_WAIT) && i_ee_ack
        && (byte_idx_reg == header_len - 16'h0003) && (i_ee_data != IMAGE_MARKER);
    assign reset_done_pulse = reset_busy_reg && (reset_cnt_reg <= 8'h01)
        && !soft_reset_start;
    assign wake_pulse = (power_reg == PW_RECOVER) && (recover_cnt_reg <= 8'h01);
    assign event_set = {reset_done_pulse, load_err_pulse, load_done_pulse, wake_pulse};

    // sticky events, write one to clear, a new event wins over the clear
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            event_status_reg <= 4'h0;
            event_mask_reg <= 4'h0;
        end else begin
            if (i_reg_wr && (i_reg_addr == ADDR_EVENT_MASK)) begin
                event_mask_reg <= i_reg_wdata[3:0];
            end
            if (i_reg_wr && (i_reg_addr == ADDR_EVENT_STATUS)) begin
                event_status_reg <= (event_status_reg & ~i_reg_wdata[3:0]) | event_set;
            end else begin
                event_status_reg <= event_status_reg | event_set;
            end
        end
    end

    // ready level: busy during recovery, image load or soft reset
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ready_reg <= 1'b0;
        end else begin
            // a power down request alone never touches ready
            ready_reg <= (power_reg != PW_RECOVER)
                && (load_reg == LD_IDLE) && !start_load
                && !reset_busy_reg && !soft_reset_start;
        end
    end

    // shared pin, status change pin and block interrupt
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ready_irq_pin <= 1'b0;
            o_status_change_pin <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            if (config_option_reg[BIT_IO_MEM_MODE]) begin
                o_ready_irq_pin <= interrupt_pending_flag;
            end else begin
                o_ready_irq_pin <= ready_reg;
            end
            o_status_change_pin <= (changed_src_en_reg && changed_flag)
                || (ring_src_en_reg && ring_meta_reg[1]);
            o_irq <= |((event_status_reg | event_set) & event_mask_reg);
        end
    end

    // read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (!i_reg_rd) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_addr == ADDR_CLOCK_CONTROL) begin
            o_reg_rdata <= {6'h00, clock_control_reg};
        end else if (i_reg_addr == ADDR_CARD_STATUS) begin
            o_reg_rdata <= {3'h0, changed_flag, changed_src_en_reg, ring_src_en_reg,
                power_down_request, interrupt_pending_flag};
        end else if (i_reg_addr == ADDR_CONFIG_OPTION) begin
            o_reg_rdata <= config_option_reg;
        end else if (i_reg_addr == ADDR_EXT_IRQ_ENABLE) begin
            o_reg_rdata <= {2'h0, ext_enable_reg};
        end else if (i_reg_addr == ADDR_EVENT_STATUS) begin
            o_reg_rdata <= {4'h0, event_status_reg};
        end else if (i_reg_addr == ADDR_EVENT_MASK) begin
            o_reg_rdata <= {4'h0, event_mask_reg};
        end else if (i_reg_addr == ADDR_BLOCK_STATUS) begin
            o_reg_rdata <= {2'h0, load_error_reg, load_reg != LD_IDLE,
                reset_busy_reg, power_reg, ready_reg};
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end
    // the card has no address bit 24 input and no i/o space pins
endmodule

// ### verif/pccard_power_ready_ctrl_assertions.sv
// concurrent checks on the block's ports
`timescale 1ns/1ps
module pccard_power_ready_ctrl_assertions
    import pccard_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire cm_write_t o_cm_write,
    input wire logic [5:0] i_external_irq_inputs,
    input wire logic i_comm_processor_irq,
    input wire logic o_ee_rd,
    input wire logic [15:0] o_ee_addr,
    input wire logic i_ee_ack,
    input wire dpr_write_t o_dual_port_ram_wr,
    input wire logic o_osc_enable,
    input wire logic o_int_clk_enable,
    input wire logic o_ready_irq_pin
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    // register write strobes
    logic wr_status, wr_option;
    assign wr_status = i_reg_wr && i_reg_addr == ADDR_CARD_STATUS;
    assign wr_option = i_reg_wr && i_reg_addr == ADDR_CONFIG_OPTION;
    a_stop_gates_clocks: assert property (!o_osc_enable |-> !o_int_clk_enable)
        else $error("clocks run in stop");
    a_pd_ready_kept: assert property (wr_status && i_reg_wdata[BIT_POWER_DOWN]
        && o_ready_irq_pin && !i_comm_processor_irq && i_external_irq_inputs == 6'h00
        |=> o_ready_irq_pin [*3]) else $error("ready moved on power down");
    a_soft_reset_busy: assert property (wr_option && i_reg_wdata[BIT_SOFT_RESET]
        && !i_reg_wdata[BIT_IO_MEM_MODE] |=> ##1 !o_ready_irq_pin [*8])
        else $error("ready not busy during soft reset");
    a_ee_read_pulse: assert property (o_ee_rd |=> !o_ee_rd)
        else $error("eeprom read too long");
    a_ee_addr_hold: assert property (o_ee_rd |=> $stable(o_ee_addr))
        else $error("eeprom address moved under a request");
    a_dpr_after_ack: assert property (o_dual_port_ram_wr.valid
        |-> $past(i_ee_ack) || $past(i_ee_ack, 2)) else $error("ram write without eeprom byte");
    a_cm_write_pulse: assert property (o_cm_write.valid |=> !o_cm_write.valid)
        else $error("common write too long");
    a_rdata_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("stray read data");
    c_stop: cover property (!o_osc_enable);
    c_image_write: cover property (o_dual_port_ram_wr.valid);
    c_steer: cover property (o_cm_write.valid);
endmodule

// ### verif/serial_eeprom_model.sv
// serial eeprom with a short image
`timescale 1ns/1ps
module serial_eeprom_model (
    input wire logic i_sys_clk,
    input wire logic i_ee_rd,
    input wire logic [15:0] i_ee_addr,
    output logic o_ee_ack,
    output logic [7:0] o_ee_data
);
    // eight bit address layout: reserved, marker, size high, size low, data
    logic [7:0] mem [8] = '{8'hFF, 8'h02, 8'h00, 8'h02, 8'hA5, 8'h5A, 8'h00, 8'h00};
    logic busy = 1'b0;
    logic [2:0] cnt = 3'h0;
    initial begin
        o_ee_ack = 1'b0;
        o_ee_data = 8'h00;
    end
    // odd addresses answer late; idle data toggles
    always @(posedge i_sys_clk) begin
        o_ee_ack <= 1'b0;
        o_ee_data <= ~o_ee_data;
        if (i_ee_rd) begin
            busy <= 1'b1;
            cnt <= i_ee_addr[0] ? 3'h4 : 3'h0;
        end else if (busy && cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end else if (busy) begin
            busy <= 1'b0;
            o_ee_ack <= 1'b1;
            o_ee_data <= mem[i_ee_addr[2:0]];
        end
    end
endmodule

// ### verif/pccard_power_ready_ctrl_tb.sv
// self-checking bench for the block
`timescale 1ns/1ps
module pccard_power_ready_ctrl_tb;
    import pccard_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    pc_bus_t i_pc_bus = {5'h1D, 16'h0000};
    logic i_ring_indicate_input = 1'b0, i_comm_processor_irq = 1'b0, i_eeprom_addr16 = 1'b0;
    logic [5:0] i_external_irq_inputs = 6'h00;
    logic i_serial_eeprom_image_mode = 1'b1;
    logic [7:0] i_ee_data, o_reg_rdata;
    cm_write_t o_cm_write, cm_last;
    logic [15:0] o_ee_addr;
    dpr_write_t o_dual_port_ram_wr;
    logic i_ee_ack, o_ee_rd, o_osc_enable, o_int_clk_enable;
    logic o_ready_irq_pin, o_status_change_pin, o_irq;
    logic [23:0] dpr_last;
    int dpr_n = 0, num_errors = 0, num_checks = 0;
    pccard_power_ready_ctrl dut (.i_sys_clk, .i_rstn, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .i_pc_bus, .o_cm_write, .i_ring_indicate_input,
        .i_external_irq_inputs, .i_comm_processor_irq, .i_serial_eeprom_image_mode,
        .i_eeprom_addr16, .o_ee_rd, .o_ee_addr, .i_ee_ack, .i_ee_data, .o_dual_port_ram_wr,
        .o_osc_enable, .o_int_clk_enable, .o_ready_irq_pin, .o_status_change_pin, .o_irq);
    serial_eeprom_model eeprom (.i_sys_clk, .i_ee_rd(o_ee_rd), .i_ee_addr(o_ee_addr),
        .o_ee_ack(i_ee_ack), .o_ee_data(i_ee_data));
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    // record image and steered writes
    always @(posedge i_sys_clk) begin
        if (o_dual_port_ram_wr.valid) begin
            dpr_n++;
            dpr_last = {5'h00, o_dual_port_ram_wr.addr, o_dual_port_ram_wr.data};
        end
        if (o_cm_write.valid) begin
            cm_last = o_cm_write;
        end
    end
    task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1 chk("rdata", 24'(o_reg_rdata & m), 24'(e));
    endtask
    task automatic pins(input int n, input string s, input logic [4:0] m, input logic [4:0] e);
        repeat (n) @(negedge i_sys_clk);
        chk(s, 24'({o_osc_enable, o_int_clk_enable, o_ready_irq_pin, o_status_change_pin,
            o_irq} & m), 24'(e));
    endtask
    task automatic wait_ready(input logic v);
        int n;
        n = 0;
        while (o_ready_irq_pin !== v && n < 300) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("ready", 24'(o_ready_irq_pin), 24'(v));
    endtask
    task automatic t_boot();
        wait_ready(1'b1);
        chk("image writes", 24'(dpr_n), 24'h000002);
        chk("last image write", dpr_last, {5'h00, 11'h001, 8'h5A});
        rdc(ADDR_EVENT_STATUS, 8'h02, 8'h02);
        rdc(4'hF, 8'hFF, 8'h00);
    endtask
    task automatic t_power();
        wr(ADDR_CARD_STATUS, 8'h02);
        rdc(ADDR_CARD_STATUS, 8'h02, 8'h00);
        wr(ADDR_CLOCK_CONTROL, 8'h01);
        wr(ADDR_CARD_STATUS, 8'h02);
        pins(3, "standby", 5'h1C, 5'h14);
        wr(ADDR_CARD_STATUS, 8'h00);
        wait_ready(1'b0);
        wait_ready(1'b1);
        wr(ADDR_CLOCK_CONTROL, 8'h03);
        wr(ADDR_CARD_STATUS, 8'h02);
        pins(3, "stop", 5'h18, 5'h00);
        i_ring_indicate_input <= 1'b1;
        wait_ready(1'b0);
        wait_ready(1'b1);
        i_ring_indicate_input <= 1'b0;
        rdc(ADDR_CARD_STATUS, 8'h02, 8'h00);
        wr(ADDR_EVENT_MASK, 8'h01);
        pins(2, "irq on", 5'h01, 5'h01);
        wr(ADDR_EVENT_STATUS, 8'h01);
        pins(2, "irq off", 5'h01, 5'h00);
    endtask
    task automatic t_irq();
        wr(ADDR_CONFIG_OPTION, 8'h01);
        i_comm_processor_irq <= 1'b1;
        pins(3, "cp irq", 5'h04, 5'h04);
        i_comm_processor_irq <= 1'b0;
        wr(ADDR_EXT_IRQ_ENABLE, 8'h01);
        i_external_irq_inputs <= 6'h01;
        pins(4, "ext irq", 5'h04, 5'h04);
        i_external_irq_inputs <= 6'h00;
        pins(4, "irq low", 5'h04, 5'h00);
        wr(ADDR_CONFIG_OPTION, 8'h00);
        i_comm_processor_irq <= 1'b1;
        rdc(ADDR_CARD_STATUS, 8'h01, 8'h01);
        i_comm_processor_irq <= 1'b0;
        wr(ADDR_CARD_STATUS, 8'h04);
        i_ring_indicate_input <= 1'b1;
        pins(4, "ring change", 5'h02, 5'h02);
        i_ring_indicate_input <= 1'b0;
        pins(4, "ring gone", 5'h02, 5'h00);
        wr(ADDR_CARD_STATUS, 8'h08);
        pins(2, "changed", 5'h02, 5'h02);
    endtask
    task automatic t_steer();
        logic [2:0] sel [3] = '{3'b100, 3'b101, 3'b000};
        logic [17:0] exp [3] = '{{2'b01, 16'h0034}, {2'b10, 16'h3400}, {2'b11, 16'h1234}};
        for (int k = 0; k < 3; k++) begin
            cm_last = '0;
            @(posedge i_sys_clk);
            i_pc_bus <= {1'b1, sel[k], 1'b0, 16'h1234};
            repeat (4) @(posedge i_sys_clk);
            i_pc_bus.we_n <= 1'b1;
            repeat (8) @(negedge i_sys_clk);
            chk("steer", 24'({cm_last.lanes, cm_last.data & {{8{cm_last.lanes[1]}},
                {8{cm_last.lanes[0]}}}}), 24'(exp[k]));
        end
    endtask
    task automatic t_soft();
        wait_ready(1'b1);
        i_eeprom_addr16 <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        wr(ADDR_CONFIG_OPTION, 8'h80);
        wait_ready(1'b0);
        wait_ready(1'b1);
        rdc(ADDR_EVENT_STATUS, 8'h0C, 8'h0C);
    endtask
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        t_boot();
        t_power();
        t_irq();
        t_steer();
        t_soft();
        summarize();
    end
    // watchdog far beyond the run length
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end
endmodule
bind pccard_power_ready_ctrl pccard_power_ready_ctrl_assertions u_chk (.i_sys_clk, .i_rstn,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_cm_write,
    .i_external_irq_inputs, .i_comm_processor_irq, .o_ee_rd, .o_ee_addr, .i_ee_ack,
    .o_dual_port_ram_wr, .o_osc_enable, .o_int_clk_enable, .o_ready_irq_pin);
